// ==== rtl/iat_defines.svh ====
// Register map, field positions, reset values and widths for the input alarm threshold bank
`ifndef IAT_DEFINES_SVH
`define IAT_DEFINES_SVH

`define IAT_ADDR_W 8
`define IAT_ADDR_HIGH_LIMIT 8'h24
`define IAT_ADDR_LOW_LIMIT 8'h28
`define IAT_ADDR_ALARM_STATUS 8'h20
`define IAT_ADDR_IRQ_STATUS 8'h30
`define IAT_ADDR_IRQ_MASK 8'h34

`define IAT_HYST_MSB 31
`define IAT_HYST_LSB 24
`define IAT_HYST_AMT_MSB 31
`define IAT_HYST_AMT_LSB 30
`define IAT_LIMIT_MSB 15
`define IAT_LIMIT_LSB 0
`define IAT_CMP_MSB 15
`define IAT_CMP_LSB 4

`define IAT_HYST_RESET 8'h00
`define IAT_HIGH_LIMIT_RESET 16'hFFFF
`define IAT_LOW_LIMIT_RESET 16'h0000

`define IAT_ST_OVERALL 0
`define IAT_ST_TRIP_HIGH 4
`define IAT_ST_TRIP_LOW 5
`define IAT_ST_ACT_HIGH 10
`define IAT_ST_ACT_LOW 11

`define IAT_IRQ_HIGH 0
`define IAT_IRQ_LOW 1
`define IAT_IRQ_W 2

`endif

// ==== rtl/iat_pkg.sv ====
// Types shared by the input alarm threshold bank
package iat_pkg;
  typedef logic [11:0] iat_code_t;
  typedef logic [31:0] iat_word_t;
endpackage

// ==== rtl/iat_regs.sv ====
// Input alarm threshold register bank with comparators and interrupt
// Notes on behaviour
// - Hysteresis field sits in bits 31:24 of high register, resets zero, top two used.
// - Bits 23:16 of the high register are read-only and read zero.
// - High limit bits 15:0 read/write, reset all ones, compare uses 15:4.
// - High register spans byte addresses 24h to 27h, low byte first.
// - Low register spans byte addresses 28h to 2Bh, low byte first.
// - Low limit bits 15:0 read/write, reset zero, compare uses 15:4.
// - Upper sixteen bits of the low register are read-only and read zero.
// - Overall alarm bit is the OR of all tripped alarm flags.
// - Separate read-only active and tripped flags for input high and low.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "iat_defines.svh"
module iat_regs #(
  parameter int CODE_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [`IAT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_sample_valid,
  input wire logic [CODE_W-1:0] i_sample,
  output logic o_alarm_high,
  output logic o_alarm_low,
  output logic o_overall_tripped_alarm,
  output logic o_irq
);
  // Word decode: any byte address 24h..27h selects the same register
  function automatic logic addr_hit(input logic [`IAT_ADDR_W-1:0] a,
                                    input logic [`IAT_ADDR_W-1:0] base);
    addr_hit = (a[`IAT_ADDR_W-1:2] == base[`IAT_ADDR_W-1:2]);
  endfunction

  logic [7:0] input_alarm_hysteresis_reg;
  logic [7:0] input_alarm_hysteresis_next;
  logic [15:0] input_alarm_upper_limit_reg;
  logic [15:0] input_alarm_upper_limit_next;
  logic [15:0] input_alarm_lower_limit_reg;
  logic [15:0] input_alarm_lower_limit_next;
  logic tripped_input_high_flag_reg;
  logic tripped_input_high_flag_next;
  logic tripped_input_low_flag_reg;
  logic tripped_input_low_flag_next;
  logic [`IAT_IRQ_W-1:0] irq_status_reg;
  logic [`IAT_IRQ_W-1:0] irq_status_next;
  logic [`IAT_IRQ_W-1:0] irq_mask_reg;
  logic [`IAT_IRQ_W-1:0] irq_mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic active_high;
  logic active_low;
  logic active_high_d_reg;
  logic active_low_d_reg;
  logic [`IAT_IRQ_W-1:0] rise;
  logic overall;
  iat_pkg::iat_word_t high_word;
  iat_pkg::iat_word_t low_word;
  iat_pkg::iat_word_t status_word;

  iat_window_cmp #(.CODE_W(CODE_W), .UPPER(1'b1)) u_cmp_high (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sample_valid(i_sample_valid),
    .i_sample(i_sample),
    .i_limit(input_alarm_upper_limit_reg[`IAT_CMP_MSB:`IAT_CMP_LSB]),
    .i_hyst(input_alarm_hysteresis_reg[`IAT_HYST_AMT_MSB-`IAT_HYST_LSB:
                                       `IAT_HYST_AMT_LSB-`IAT_HYST_LSB]),
    .o_active(active_high)
  );

  iat_window_cmp #(.CODE_W(CODE_W), .UPPER(1'b0)) u_cmp_low (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sample_valid(i_sample_valid),
    .i_sample(i_sample),
    .i_limit(input_alarm_lower_limit_reg[`IAT_CMP_MSB:`IAT_CMP_LSB]),
    .i_hyst(input_alarm_hysteresis_reg[`IAT_HYST_AMT_MSB-`IAT_HYST_LSB:
                                       `IAT_HYST_AMT_LSB-`IAT_HYST_LSB]),
    .o_active(active_low)
  );

  assign rise = {active_low & ~active_low_d_reg, active_high & ~active_high_d_reg};

  always_comb begin
    high_word = 32'h0000_0000;
    high_word[`IAT_HYST_MSB:`IAT_HYST_LSB] = input_alarm_hysteresis_reg;
    high_word[`IAT_LIMIT_MSB:`IAT_LIMIT_LSB] = input_alarm_upper_limit_reg;
    low_word = 32'h0000_0000;
    low_word[`IAT_LIMIT_MSB:`IAT_LIMIT_LSB] = input_alarm_lower_limit_reg;
    // overall is OR of tripped flags
    overall = tripped_input_high_flag_reg | tripped_input_low_flag_reg;
    status_word = 32'h0000_0000;
    status_word[`IAT_ST_ACT_HIGH] = active_high;
    status_word[`IAT_ST_ACT_LOW] = active_low;
    status_word[`IAT_ST_TRIP_HIGH] = tripped_input_high_flag_reg;
    status_word[`IAT_ST_TRIP_LOW] = tripped_input_low_flag_reg;
    status_word[`IAT_ST_OVERALL] = overall;
  end

  always_comb begin
    input_alarm_hysteresis_next = input_alarm_hysteresis_reg;
    input_alarm_upper_limit_next = input_alarm_upper_limit_reg;
    input_alarm_lower_limit_next = input_alarm_lower_limit_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    rdata_next = 32'h0000_0000;
    if (i_wr) begin
      if (addr_hit(i_addr, `IAT_ADDR_HIGH_LIMIT)) begin
        input_alarm_hysteresis_next = i_wdata[`IAT_HYST_MSB:`IAT_HYST_LSB];
        // limit stored whole, low nibble kept as written
        input_alarm_upper_limit_next = i_wdata[`IAT_LIMIT_MSB:`IAT_LIMIT_LSB];
      end
      if (addr_hit(i_addr, `IAT_ADDR_LOW_LIMIT)) begin
        input_alarm_lower_limit_next = i_wdata[`IAT_LIMIT_MSB:`IAT_LIMIT_LSB];
      end
      if (addr_hit(i_addr, `IAT_ADDR_IRQ_MASK)) begin
        irq_mask_next = i_wdata[`IAT_IRQ_W-1:0];
      end
      if (addr_hit(i_addr, `IAT_ADDR_IRQ_STATUS)) begin
        irq_status_next = irq_status_reg & ~i_wdata[`IAT_IRQ_W-1:0];
      end
    end
    // Set wins over a same-cycle clear so no trip is lost
    irq_status_next = irq_status_next | rise;
    if (i_rd) begin
      if (addr_hit(i_addr, `IAT_ADDR_HIGH_LIMIT)) begin
        rdata_next = high_word;
      end else if (addr_hit(i_addr, `IAT_ADDR_LOW_LIMIT)) begin
        rdata_next = low_word;
      end else if (addr_hit(i_addr, `IAT_ADDR_ALARM_STATUS)) begin
        rdata_next = status_word;
      end else if (addr_hit(i_addr, `IAT_ADDR_IRQ_STATUS)) begin
        rdata_next = {{(32 - `IAT_IRQ_W){1'b0}}, irq_status_reg};
      end else if (addr_hit(i_addr, `IAT_ADDR_IRQ_MASK)) begin
        rdata_next = {{(32 - `IAT_IRQ_W){1'b0}}, irq_mask_reg};
      end
    end
  end

  always_comb begin
    // tripped flags follow the live condition
    tripped_input_high_flag_next = active_high;
    tripped_input_low_flag_next = active_low;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      input_alarm_hysteresis_reg <= `IAT_HYST_RESET;
      input_alarm_upper_limit_reg <= `IAT_HIGH_LIMIT_RESET;
      input_alarm_lower_limit_reg <= `IAT_LOW_LIMIT_RESET;
      irq_status_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      tripped_input_high_flag_reg <= 1'b0;
      tripped_input_low_flag_reg <= 1'b0;
      active_high_d_reg <= 1'b0;
      active_low_d_reg <= 1'b0;
    end else begin
      input_alarm_hysteresis_reg <= input_alarm_hysteresis_next;
      input_alarm_upper_limit_reg <= input_alarm_upper_limit_next;
      input_alarm_lower_limit_reg <= input_alarm_lower_limit_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      tripped_input_high_flag_reg <= tripped_input_high_flag_next;
      tripped_input_low_flag_reg <= tripped_input_low_flag_next;
      active_high_d_reg <= active_high;
      active_low_d_reg <= active_low;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_alarm_high = active_high;
  assign o_alarm_low = active_low;
  assign o_overall_tripped_alarm = tripped_input_high_flag_reg | tripped_input_low_flag_reg;
  // Level output while any unmasked sticky bit stands
  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // Elaboration check: limit slices feed exactly twelve code bits
  if (CODE_W != 12) begin : g_code_w_check
    $error("iat_regs: comparison field is 12 bits wide");
  end
endmodule
`default_nettype wire

// ==== rtl/iat_window_cmp.sv ====
// One-sided alarm comparator with hysteresis release
`timescale 1ns/100ps
`default_nettype none
module iat_window_cmp #(
  parameter int CODE_W = 12,
  parameter bit UPPER = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sample_valid,
  input wire logic [CODE_W-1:0] i_sample,
  input wire logic [CODE_W-1:0] i_limit,
  input wire logic [1:0] i_hyst,
  output logic o_active
);
  logic active_reg;
  logic active_next;
  logic [CODE_W:0] release_lvl;

  always_comb begin
    // Released level is one bit wider so the low-side sum never wraps; the high-side difference wraps when i_limit is below i_hyst
    if (UPPER) begin
      release_lvl = {1'b0, i_limit} - {{(CODE_W - 1){1'b0}}, i_hyst};
    end else begin
      release_lvl = {1'b0, i_limit} + {{(CODE_W - 1){1'b0}}, i_hyst};
    end
    active_next = active_reg;
    if (i_sample_valid) begin
      if (UPPER) begin
        if (i_sample > i_limit) begin
          active_next = 1'b1;
        end else if ({1'b0, i_sample} <= release_lvl ||
                     i_limit < {{(CODE_W - 2){1'b0}}, i_hyst}) begin
          active_next = 1'b0;
        end
      end else begin
        if (i_sample < i_limit) begin
          active_next = 1'b1;
        end else if ({1'b0, i_sample} >= release_lvl) begin
          active_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  assign o_active = active_reg;

  // Elaboration check: hysteresis padding needs at least three code bits
  if (CODE_W < 3) begin : g_code_w_check
    $error("iat_window_cmp: CODE_W too small");
  end
endmodule
`default_nettype wire

// ==== test/iat_regs_bench.sv ====
// Self-checking bench for the input alarm threshold bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module iat_regs_bench;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_sample_valid = 1'b0;
  logic [11:0] i_sample = 12'h000;
  logic [31:0] o_rdata;
  logic o_alarm_high, o_alarm_low, o_overall_tripped_alarm, o_irq;
  int fail_count = 0;
  int checks_done = 0;
  iat_regs #(.CODE_W(12)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample), .o_alarm_high(o_alarm_high),
    .o_alarm_low(o_alarm_low), .o_overall_tripped_alarm(o_overall_tripped_alarm), .o_irq(o_irq));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  task automatic smp(input logic [11:0] s, input logic eh, input logic el);
    @(posedge i_clk);
    i_sample_valid <= 1'b1;
    i_sample <= s;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    #1 `CHK(o_alarm_high, eh)
    `CHK(o_alarm_low, el)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Limit is far above the expected run of about 70 cycles
  initial begin
    #50000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h24, 32'h0000FFFF);
    rd(8'h28, 32'h00000000);
    smp(12'hFFF, 1'b0, 1'b0);
    smp(12'h000, 1'b0, 1'b0);
    $display("test reset values done");
    wr(8'h27, 32'hFFFFFFF0);
    rd(8'h24, 32'hFF00FFF0);
    wr(8'h29, 32'hFFFFFFF0);
    rd(8'h2B, 32'h0000FFF0);
    rd(8'h3C, 32'h00000000);
    $display("test map and reserved done");
    wr(8'h24, 32'h80000800);
    wr(8'h28, 32'h00000400);
    wr(8'h34, 32'h00000001);
    smp(12'h080, 1'b0, 1'b0);
    smp(12'h081, 1'b1, 1'b0);
    rd(8'h20, 32'h00000411);
    `CHK(o_overall_tripped_alarm, 1'b1)
    `CHK(o_irq, 1'b1)
    rd(8'h30, 32'h00000001);
    smp(12'h07F, 1'b1, 1'b0);
    smp(12'h07E, 1'b0, 1'b0);
    wr(8'h30, 32'h00000001);
    #1 `CHK(o_irq, 1'b0)
    smp(12'h03F, 1'b0, 1'b1);
    rd(8'h20, 32'h00000821);
    `CHK(o_irq, 1'b0)
    wr(8'h34, 32'h00000003);
    #1 `CHK(o_irq, 1'b1)
    rd(8'h34, 32'h00000003);
    rd(8'h30, 32'h00000002);
    smp(12'h041, 1'b0, 1'b1);
    smp(12'h042, 1'b0, 1'b0);
    wr(8'h30, 32'h00000003);
    #1 `CHK(o_irq, 1'b0)
    rd(8'h20, 32'h00000000);
    `CHK(o_overall_tripped_alarm, 1'b0)
    $display("test alarms and interrupt done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== test/iat_regs_sva.sv ====
// Port assertions for the input alarm threshold bank
`timescale 1ns/100ps
`default_nettype none
`include "iat_defines.svh"
module iat_regs_sva #(
  parameter int CODE_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [`IAT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_sample_valid,
  input wire logic [CODE_W-1:0] i_sample,
  input wire logic o_alarm_high,
  input wire logic o_alarm_low,
  input wire logic o_overall_tripped_alarm,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic rd_q;
  logic [5:0] word_q;
  logic [31:0] high_exp_q;
  logic [31:0] low_exp_q;
  // Expected register images, rebuilt from reset values and writes seen
  always_ff @(posedge i_clk) begin
    rd_q <= i_rd;
    word_q <= i_addr[7:2];
    if (!i_rstn) begin
      high_exp_q <= 32'h0000FFFF;
      low_exp_q <= 32'h00000000;
    end else if (i_wr && (i_addr[7:2] == 6'h09)) begin
      high_exp_q <= {i_wdata[31:24], 8'h00, i_wdata[15:0]};
    end else if (i_wr && (i_addr[7:2] == 6'h0A)) begin
      low_exp_q <= {16'h0000, i_wdata[15:0]};
    end
  end
  sequence read_of_s(logic [5:0] w);
    rd_q && (word_q == w);
  endsequence
  sequence high_trip_s;
    $rose(o_alarm_high);
  endsequence
  // Read data only in the cycle after a read
  a_rdata_idle: assert property (!rd_q |-> o_rdata == 32'h00000000) else $error("rdata not idle");
  a_rsvd_high: assert property (read_of_s(6'h09) |-> o_rdata[23:16] == 8'h00) else $error("rsvd high");
  a_rsvd_low: assert property (read_of_s(6'h0A) |-> o_rdata[31:16] == 16'h0000) else $error("rsvd low");
  a_status_bits: assert property (read_of_s(6'h08) |-> (o_rdata & ~32'h00000C31) == 32'h0) else $error("status bits");
  a_overall_or: assert property (o_overall_tripped_alarm == ($past(o_alarm_high) || $past(o_alarm_low))) else $error("overall");
  a_trip_follow: assert property (high_trip_s |=> o_overall_tripped_alarm) else $error("trip follow");
  a_high_cause: assert property ($rose(o_alarm_high) |-> $past(i_sample_valid)) else $error("high cause");
  a_low_cause: assert property ($rose(o_alarm_low) |-> $past(i_sample_valid)) else $error("low cause");
  a_high_hold: assert property (!$past(i_sample_valid) |-> $stable(o_alarm_high)) else $error("high hold");
  a_low_hold: assert property (!$past(i_sample_valid) |-> $stable(o_alarm_low)) else $error("low hold");
  a_high_back: assert property (read_of_s(6'h09) |-> o_rdata == high_exp_q)
    else $error("high readback");
  a_low_back: assert property (read_of_s(6'h0A) |-> o_rdata == low_exp_q)
    else $error("low readback");
  a_high_set: assert property (i_sample_valid && (i_sample > high_exp_q[15:4]) |=> o_alarm_high)
    else $error("high not set");
  a_low_set: assert property (i_sample_valid && (i_sample < low_exp_q[15:4]) |=> o_alarm_low)
    else $error("low not set");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_wr) ||
    ($past(o_alarm_high) && !$past(o_alarm_high, 2)) || ($past(o_alarm_low) && !$past(o_alarm_low, 2)))
    else $error("irq without cause");
endmodule
bind iat_regs iat_regs_sva #(.CODE_W(CODE_W)) u_sva (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_sample_valid(i_sample_valid), .i_sample(i_sample), .o_alarm_high(o_alarm_high),
  .o_alarm_low(o_alarm_low), .o_overall_tripped_alarm(o_overall_tripped_alarm), .o_irq(o_irq));
`default_nettype wire
